// ===== rtl/dce_pkg.sv
package dce_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam int                   ADDR_W          = 4;
  localparam logic [ADDR_W-1:0]    OFF_EVENT_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0]    OFF_INT_CTRL    = 4'h4;
  localparam logic [ADDR_W-1:0]    OFF_CHAN_CTRL   = 4'h8;

  // ==========================================================
  // channel_event_control fields
  localparam int                   EV_ABORT_SEL_LSB = 16;
  localparam int                   EV_START_SEL_LSB = 8;
  localparam int                   EV_FORCE_BIT     = 7;
  localparam int                   EV_SWABORT_BIT   = 6;
  localparam int                   EV_PATTERN_ABORT_ENABLE_BIT     = 5;
  localparam int                   EV_START_REQUEST_ENABLE_BIT    = 4;
  localparam int                   EV_ABORT_REQUEST_ENABLE_BIT    = 3;
  localparam logic [7:0]           ABORT_SEL_RST    = 8'hFF;
  localparam logic [7:0]           START_SEL_RST    = 8'hFF;

  // ==========================================================
  // channel_interrupt_control fields
  localparam int                   INT_IE_LSB       = 16;
  localparam int                   INT_FLAG_LSB     = 0;
  localparam int                   FL_SRC_DONE      = 7;
  localparam int                   FL_SRC_HALF      = 6;
  localparam int                   FL_DST_DONE      = 5;
  localparam int                   FL_DST_HALF      = 4;
  localparam int                   FL_BLOCK         = 3;
  localparam int                   FL_CELL          = 2;
  localparam int                   FL_ABORT         = 1;
  localparam int                   FL_ADDR_ERR      = 0;

  // ==========================================================
  // channel control fields
  localparam int                   CC_BUSY_BIT      = 15;
  localparam int                   CC_ON_BIT        = 7;
  localparam int                   CC_ALLOW_BIT     = 6;
  localparam int                   CC_AUTO_BIT      = 4;

  // ==========================================================
  // pointer compare slots
  localparam int                   EQ_SRC_DONE      = 4;
  localparam int                   EQ_SRC_HALF      = 3;
  localparam int                   EQ_DST_DONE      = 2;
  localparam int                   EQ_DST_HALF      = 1;
  localparam int                   EQ_BLOCK         = 0;

  typedef enum logic {DCE_IDLE, DCE_RUN} dce_state_t;
endpackage

// ===== rtl/dce_chan_ctrl.sv
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/10ps
// Function
// RL1: abort selector picks irq 0..255; its event aborts transfer and sets abort flag
// RL2: start selector picks irq 0..255; its event starts a transfer when enabled
// RL3: writing one to force_transfer starts a transfer; bit reads zero
// RL4: writing one to software_abort aborts the transfer; bit reads zero
// RL5: pattern_abort_enable set: pattern match aborts and clears channel_on
// RL6: start_request_enable gates start selector events; clear means ignored
// RL7: abort_request_enable gates abort selector events; clear means ignored
// RL8: eight enable bits in upper byte gate the eight status flags; here the enables sit in bits 23:16, not 31:24
// RL9: source done flag when source pointer equals source size
// RL10: source half flag when source pointer equals half source size
// RL11: destination done flag when destination pointer equals destination size
// RL12: destination half flag when destination pointer equals half destination size
// RL13: block flag when larger size moved, or on pattern match; here a pattern match sets it only while pattern_abort_enable is set
// RL14: cell flag each time a cell has been transferred
// RL15: abort flag when matching abort irq detected and transfer aborted
// RL16: address error flag when source or destination address invalid
// RL17: events while channel off only registered if allow_events_while_off set
// RL18: block completion clears channel_on unless auto_reenable set
// RL19: interrupt output high while any flag and its enable are both set
module dce_chan_ctrl (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  input  wire logic [dce_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [31:0]                 wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [31:0]                 rdata_o,
  input  wire logic                        irq_valid_i,
  input  wire logic [7:0]                  irq_num_i,
  input  wire logic [16:0]                 source_pointer_i,
  input  wire logic [16:0]                 destination_pointer_i,
  input  wire logic [15:0]                 source_size_i,
  input  wire logic [15:0]                 destination_size_i,
  input  wire logic [16:0]                 bytes_moved_i,
  input  wire logic                        cell_done_i,
  input  wire logic                        pattern_match_i,
  input  wire logic                        addr_error_i,
  output logic                             start_o,
  output logic                             abort_o,
  output logic                             busy_o,
  output logic                             channel_on_o,
  output logic                             irq_o
);
  import dce_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]  abort_irq_select;
    logic [7:0]  start_irq_select;
    logic        pattern_abort_enable;
    logic        start_request_enable;
    logic        abort_request_enable;
    logic        channel_on;
    logic        allow_events_while_off;
    logic        auto_reenable;
    logic [7:0]  flags;
    logic [7:0]  ie;
    logic        pend_start;
    dce_state_t  state;
    logic [4:0]  eq_q;
    logic        start_p;
    logic        abort_p;
    logic        irq;
    logic [31:0] rdata;
  } dce_regs_t;

  dce_regs_t q;
  dce_regs_t next_q;

  // size code 0 means 65536 bytes
  function automatic logic [16:0] eff_size(input logic [15:0] s);
    eff_size = (s == 16'h0000) ? 17'h1_0000 : {1'b0, s};
  endfunction

  // ==========================================================
  // combinational
  logic        wr_ev;
  logic        wr_int;
  logic        wr_cc;
  logic        ev_ok;
  logic        irq_start;
  logic        irq_abort;
  logic        sw_force;
  logic        sw_abort;
  logic        pat_abort;
  logic        abort_now;
  logic        running;
  logic        blk_done;
  logic [16:0] src_sz;
  logic [16:0] dst_sz;
  logic [16:0] max_sz;
  logic [4:0]  eq_now;
  logic [4:0]  eq_rise;
  logic [7:0]  fl_set;
  logic [7:0]  fl_clr;

  always_comb begin
    next_q   = q;
    wr_ev    = wr_i && (addr_i == OFF_EVENT_CTRL);
    wr_int   = wr_i && (addr_i == OFF_INT_CTRL);
    wr_cc    = wr_i && (addr_i == OFF_CHAN_CTRL);
    running  = (q.state == DCE_RUN);
    ev_ok    = q.channel_on || q.allow_events_while_off;                 // [RL17]
    irq_start = irq_valid_i && (irq_num_i == q.start_irq_select)
                && q.start_request_enable && ev_ok;                      // [RL2] [RL6]
    irq_abort = irq_valid_i && (irq_num_i == q.abort_irq_select)
                && q.abort_request_enable && ev_ok;                      // [RL1] [RL7]
    sw_force  = wr_ev && wdata_i[EV_FORCE_BIT];                          // [RL3]
    sw_abort  = wr_ev && wdata_i[EV_SWABORT_BIT];                        // [RL4]
    pat_abort = pattern_match_i && q.pattern_abort_enable;               // [RL5]
    abort_now = irq_abort || sw_abort || pat_abort;

    // pointer compares only count while a transfer runs
    src_sz = eff_size(source_size_i);
    dst_sz = eff_size(destination_size_i);
    max_sz = (src_sz > dst_sz) ? src_sz : dst_sz;
    eq_now[EQ_SRC_DONE] = running && (source_pointer_i == src_sz);       // [RL9]
    eq_now[EQ_SRC_HALF] = running && (source_pointer_i == (src_sz >> 1)); // [RL10]
    eq_now[EQ_DST_DONE] = running && (destination_pointer_i == dst_sz);  // [RL11]
    eq_now[EQ_DST_HALF] = running && (destination_pointer_i == (dst_sz >> 1)); // [RL12]
    eq_now[EQ_BLOCK]    = running && (bytes_moved_i == max_sz);          // [RL13]
    // edge detect so a pointer parked on a mark sets its flag once
    eq_rise     = eq_now & ~q.eq_q;
    next_q.eq_q = eq_now;
    blk_done    = eq_rise[EQ_BLOCK];

    fl_set              = 8'h00;
    fl_set[FL_SRC_DONE] = eq_rise[EQ_SRC_DONE];                          // [RL9]
    fl_set[FL_SRC_HALF] = eq_rise[EQ_SRC_HALF];                          // [RL10]
    fl_set[FL_DST_DONE] = eq_rise[EQ_DST_DONE];                          // [RL11]
    fl_set[FL_DST_HALF] = eq_rise[EQ_DST_HALF];                          // [RL12]
    fl_set[FL_BLOCK]    = blk_done || pat_abort;                         // [RL13]
    fl_set[FL_CELL]     = running && cell_done_i;                        // [RL14]
    fl_set[FL_ABORT]    = irq_abort;                                     // [RL15]
    fl_set[FL_ADDR_ERR] = addr_error_i;                                  // [RL16]
    fl_clr = wr_int ? wdata_i[INT_FLAG_LSB +: 8] : 8'h00;
    // a hardware set in the same cycle as a clear wins
    next_q.flags = (q.flags & ~fl_clr) | fl_set;

    // ==========================================================
    // register writes
    if (wr_ev) begin
      next_q.abort_irq_select     = wdata_i[EV_ABORT_SEL_LSB +: 8];       // [RL1]
      next_q.start_irq_select     = wdata_i[EV_START_SEL_LSB +: 8];       // [RL2]
      next_q.pattern_abort_enable = wdata_i[EV_PATTERN_ABORT_ENABLE_BIT];
      next_q.start_request_enable = wdata_i[EV_START_REQUEST_ENABLE_BIT];
      next_q.abort_request_enable = wdata_i[EV_ABORT_REQUEST_ENABLE_BIT];
    end
    if (wr_int) begin
      next_q.ie = wdata_i[INT_IE_LSB +: 8];                              // [RL8]
    end
    if (wr_cc) begin
      next_q.channel_on             = wdata_i[CC_ON_BIT];
      next_q.allow_events_while_off = wdata_i[CC_ALLOW_BIT];
      next_q.auto_reenable          = wdata_i[CC_AUTO_BIT];
    end
    // hardware disables take priority over a software write
    if (pat_abort) begin
      next_q.channel_on = 1'b0;                                          // [RL5]
    end
    if (blk_done && !q.auto_reenable) begin
      next_q.channel_on = 1'b0;                                          // [RL18]
    end

    // ==========================================================
    // transfer sequencing
    next_q.start_p = 1'b0;
    next_q.abort_p = 1'b0;
    if (irq_start || sw_force) begin
      next_q.pend_start = 1'b1;                                          // [RL3] [RL6]
    end
    case (q.state)
      DCE_IDLE: begin
        if (abort_now) begin
          next_q.pend_start = 1'b0;
        end else if (q.pend_start && q.channel_on) begin
          next_q.pend_start = 1'b0;
          next_q.start_p    = 1'b1;
          next_q.state      = DCE_RUN;
        end
      end
      DCE_RUN: begin
        if (abort_now) begin
          next_q.abort_p    = 1'b1;                                      // [RL1] [RL4] [RL5]
          next_q.pend_start = 1'b0;
          next_q.state      = DCE_IDLE;
        end else if (blk_done) begin
          next_q.state = DCE_IDLE;
        end
      end
      default: begin
        next_q.state = DCE_IDLE;
      end
    endcase

    // ==========================================================
    // read data, valid the cycle after the strobe only
    next_q.rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        OFF_EVENT_CTRL: begin
          next_q.rdata[EV_ABORT_SEL_LSB +: 8] = q.abort_irq_select;
          next_q.rdata[EV_START_SEL_LSB +: 8] = q.start_irq_select;
          next_q.rdata[EV_PATTERN_ABORT_ENABLE_BIT]          = q.pattern_abort_enable;
          next_q.rdata[EV_START_REQUEST_ENABLE_BIT]         = q.start_request_enable;
          next_q.rdata[EV_ABORT_REQUEST_ENABLE_BIT]         = q.abort_request_enable;
        end
        OFF_INT_CTRL: begin
          next_q.rdata[INT_IE_LSB +: 8]   = q.ie;
          next_q.rdata[INT_FLAG_LSB +: 8] = q.flags;
        end
        OFF_CHAN_CTRL: begin
          next_q.rdata[CC_BUSY_BIT]  = running;
          next_q.rdata[CC_ON_BIT]    = q.channel_on;
          next_q.rdata[CC_ALLOW_BIT] = q.allow_events_while_off;
          next_q.rdata[CC_AUTO_BIT]  = q.auto_reenable;
        end
        default: begin
          next_q.rdata = 32'h0000_0000;
        end
      endcase
    end

    next_q.irq = |(next_q.flags & next_q.ie);                            // [RL8] [RL19]
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q                        <= '0;
      q.abort_irq_select       <= ABORT_SEL_RST;
      q.start_irq_select       <= START_SEL_RST;
      q.state                  <= DCE_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o      = q.rdata;
  assign start_o      = q.start_p;
  assign abort_o      = q.abort_p;
  assign busy_o       = (q.state == DCE_RUN);
  assign channel_on_o = q.channel_on;
  assign irq_o        = q.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_abort_irq_flag;
    irq_valid_i && (irq_num_i == q.abort_irq_select) && q.abort_request_enable
      && q.channel_on && !wr_int |=> irq_o == (|(q.ie & q.flags)) && q.flags[FL_ABORT];
  endproperty
  a_abort_irq_flag: assert property (p_abort_irq_flag) else $error("abort irq lost"); // [RL15]

  // pattern abort is folded in so this check only sees a genuinely quiet channel
  logic abort_request_enable_chk;
  assign abort_request_enable_chk = q.abort_request_enable || q.pattern_abort_enable;
  property p_abort_irq_off;
    busy_o && !abort_request_enable_chk && !wr_i && !pattern_match_i && !blk_done
      |=> busy_o && !abort_o;
  endproperty
  a_abort_irq_off: assert property (p_abort_irq_off) else $error("ignored abort acted"); // [RL7]

  property p_force_start;
    wr_ev && wdata_i[EV_FORCE_BIT] && !wdata_i[EV_SWABORT_BIT] && !busy_o && q.channel_on
      && !irq_valid_i && !pattern_match_i ##1 (!wr_i && !irq_valid_i && !pattern_match_i)
      |-> ##[0:1] start_o;
  endproperty
  a_force_start: assert property (p_force_start) else $error("force did not start"); // [RL3]

  property p_sw_abort;
    sw_abort && busy_o |=> abort_o && !busy_o ##1 !abort_o;
  endproperty
  a_sw_abort: assert property (p_sw_abort) else $error("software abort missed"); // [RL4]

  property p_pattern;
    pattern_match_i && q.pattern_abort_enable |=> !channel_on_o && q.flags[FL_BLOCK];
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern abort missed"); // [RL5]

  property p_irq_level;
    irq_o == (|(q.flags & q.ie));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong"); // [RL19]

  property p_src_done;
    busy_o && (source_pointer_i == src_sz) && !q.eq_q[EQ_SRC_DONE] |=> q.flags[FL_SRC_DONE];
  endproperty
  a_src_done: assert property (p_src_done) else $error("source done not set"); // [RL9]

  property p_block_off;
    busy_o && blk_done && !q.auto_reenable && !wr_i |=> !channel_on_o && !busy_o;
  endproperty
  a_block_off: assert property (p_block_off) else $error("channel stayed on"); // [RL18]

  property p_off_ignored;
    irq_start && 1'b0 || (irq_valid_i && !q.channel_on && !q.allow_events_while_off
      && !q.pend_start && !wr_i) |=> !q.pend_start;
  endproperty
  a_off_ignored: assert property (p_off_ignored) else $error("event kept while off"); // [RL17]

  property p_selfclear_read;
    rd_i && (addr_i == OFF_EVENT_CTRL) |=> rdata_o[EV_FORCE_BIT] == 1'b0
      && rdata_o[EV_SWABORT_BIT] == 1'b0 && rdata_o[31:24] == 8'h00;
  endproperty
  a_selfclear_read: assert property (p_selfclear_read) else $error("strobe bit read one"); // [RL3]

  c_irq_start: cover property (irq_start && !busy_o ##[1:3] start_o);
  c_irq_abort: cover property (busy_o && irq_abort ##1 abort_o);
  c_block: cover property (busy_o && blk_done ##1 irq_o);
  c_pattern: cover property (busy_o && pat_abort);
  c_sw_abort: cover property (busy_o && sw_abort ##1 abort_o);

  // ==========================================================
  // further checks on flags, pulses and the read port
  // strobes are single-cycle so a stuck pulse would restart the engine
  property p_start_one;
    start_o |=> !start_o;
  endproperty
  a_start_one: assert property (p_start_one) else $error("start pulse too long"); // [RL3]

  property p_rdata_idle;
    !rd_i |=> rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero"); // [RL8]

  property p_cell;
    busy_o && cell_done_i |=> q.flags[FL_CELL];
  endproperty
  a_cell: assert property (p_cell) else $error("cell flag not set"); // [RL14]

  property p_addr_err;
    addr_error_i |=> q.flags[FL_ADDR_ERR];
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("address error lost"); // [RL16]

  property p_src_half;
    busy_o && (source_pointer_i == (src_sz >> 1)) && !q.eq_q[EQ_SRC_HALF]
      |=> q.flags[FL_SRC_HALF];
  endproperty
  a_src_half: assert property (p_src_half) else $error("source half not set"); // [RL10]

  property p_dst_done;
    busy_o && (destination_pointer_i == dst_sz) && !q.eq_q[EQ_DST_DONE]
      |=> q.flags[FL_DST_DONE];
  endproperty
  a_dst_done: assert property (p_dst_done) else $error("dest done not set"); // [RL11]

  property p_dst_half;
    busy_o && (destination_pointer_i == (dst_sz >> 1)) && !q.eq_q[EQ_DST_HALF]
      |=> q.flags[FL_DST_HALF];
  endproperty
  a_dst_half: assert property (p_dst_half) else $error("dest half not set"); // [RL12]

  // a start seen while idle must either launch or wait as pending
  property p_irq_start;
    irq_start && !abort_now && !busy_o |=> q.pend_start || start_o;
  endproperty
  a_irq_start: assert property (p_irq_start) else $error("start event lost"); // [RL6]

  property p_block_flag;
    busy_o && blk_done |=> q.flags[FL_BLOCK];
  endproperty
  a_block_flag: assert property (p_block_flag) else $error("block flag not set"); // [RL13]

  property p_auto_keep;
    busy_o && blk_done && q.auto_reenable && !wr_i |=> channel_on_o;
  endproperty
  a_auto_keep: assert property (p_auto_keep) else $error("auto channel dropped"); // [RL18]
endmodule

// ===== verif/dce_far_model.sv
`timescale 1ns/10ps
// ============================================================
// far side: irq sources and a byte-per-cycle transfer engine
module dce_far_model (
  input  wire logic        clk_sys_i,
  input  wire logic        busy_i,
  input  wire logic        stall_i,
  output logic             irq_valid_o,
  output logic [7:0]       irq_num_o,
  output logic [16:0]      src_ptr_o,
  output logic [16:0]      dst_ptr_o,
  output logic [15:0]      src_size_o,
  output logic [15:0]      dst_size_o,
  output logic             cell_done_o,
  output logic             pattern_o,
  output logic             addr_err_o
);
  initial begin
    irq_valid_o = 1'b0;
    cell_done_o = 1'b0;
    pattern_o   = 1'b0;
    addr_err_o  = 1'b0;
    irq_num_o   = 8'h00;
    src_ptr_o   = 17'h0_0000;
    dst_ptr_o   = 17'h0_0000;
    src_size_o  = 16'h0008;
    dst_size_o  = 16'h0004;
  end
  // pointers park at zero while idle, so a stale end value never meets a new transfer
  always @(posedge clk_sys_i) begin
    cell_done_o <= 1'b0;
    if (!busy_i) begin
      src_ptr_o <= 17'h0_0000;
      dst_ptr_o <= 17'h0_0000;
    end else if (!stall_i && src_ptr_o < {1'b0, src_size_o}) begin
      src_ptr_o   <= src_ptr_o + 17'h0_0001;
      cell_done_o <= src_ptr_o[0];
      if (dst_ptr_o < {1'b0, dst_size_o}) begin
        dst_ptr_o <= dst_ptr_o + 17'h0_0001;
      end
    end
  end
  // sizes must be nonzero and source not below destination, or the block never ends
  task automatic set_size(input logic [15:0] s, input logic [15:0] d);
    @(posedge clk_sys_i);
    src_size_o <= s;
    dst_size_o <= d;
  endtask
  task automatic fire(input logic [7:0] n);
    @(posedge clk_sys_i);
    irq_valid_o <= 1'b1;
    irq_num_o   <= n;
    @(posedge clk_sys_i);
    irq_valid_o <= 1'b0;
    irq_num_o   <= ~n; // idle number is junk, never the last one
  endtask
  task automatic pulse(input bit pat);
    @(posedge clk_sys_i);
    pattern_o  <= pat;
    addr_err_o <= !pat;
    @(posedge clk_sys_i);
    pattern_o  <= 1'b0;
    addr_err_o <= 1'b0;
  endtask
endmodule

// ===== verif/dce_chan_ctrl_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module dce_chan_ctrl_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [3:0]  addr      = 4'h0;
  logic [31:0] wdata     = 32'h0000_0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        stall     = 1'b0;
  logic [31:0] rdata;
  logic        start_o, abort_o, busy_o, channel_on_o, irq_o;
  logic        iv, cd, pm, ae;
  logic [7:0]  inum;
  logic [16:0] sp, dp;
  logic [15:0] ss, ds;
  int          n_fail    = 0;
  int          cmp_count = 0;
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  dce_far_model far (.clk_sys_i(clk_sys_i), .busy_i(busy_o), .stall_i(stall),
    .irq_valid_o(iv), .irq_num_o(inum), .src_ptr_o(sp), .dst_ptr_o(dp), .src_size_o(ss),
    .dst_size_o(ds), .cell_done_o(cd), .pattern_o(pm), .addr_err_o(ae));
  dce_chan_ctrl DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_valid_i(iv), .irq_num_i(inum),
    .source_pointer_i(sp), .destination_pointer_i(dp), .source_size_i(ss),
    .destination_size_i(ds), .bytes_moved_i(sp), .cell_done_i(cd), .pattern_match_i(pm),
    .addr_error_i(ae), .start_o(start_o), .abort_o(abort_o), .busy_o(busy_o),
    .channel_on_o(channel_on_o), .irq_o(irq_o));
  // ============================================================
  // bus access and waits
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_i);
    rd   <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  // one-cycle pulses are caught because the first look comes before any edge
  task automatic wait_out(input int k, input string nm);
    bit hit;
    hit = 1'b0;
    repeat (40) begin
      #1;
      case (k)
        0: hit = (start_o === 1'b1);
        1: hit = (abort_o === 1'b1);
        2: hit = (busy_o === 1'b1);
        default: hit = (busy_o === 1'b0);
      endcase
      if (hit) break;
      @(posedge clk_sys_i);
    end
    `CHK(nm, 1'b1, hit)
  endtask
  task automatic settle(input logic e, input string nm);
    repeat (4) @(posedge clk_sys_i);
    #1;
    `CHK(nm, e, busy_o)
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    n_fail++;
    finish_test;
  end
  // ============================================================
  // scenarios
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    far.set_size(16'h000A, 16'h0006);
    rd_reg(4'h0, 32'h00FF_FF00);
    rd_reg(4'h4, 32'h0000_0000);
    rd_reg(4'hC, 32'h0000_0000);
    wr_reg(4'h0, 32'h0021_1238);
    rd_reg(4'h0, 32'h0021_1238);
    wr_reg(4'h4, 32'h00FF_0000);
    rd_reg(4'h4, 32'h00FF_0000);
    far.fire(8'h12);
    wr_reg(4'h8, 32'h0000_0080);
    settle(1'b0, "busy_off_drop");
    far.fire(8'h13);
    settle(1'b0, "busy_other_irq");
    far.fire(8'h12);
    wait_out(0, "start_irq");
    wait_out(3, "block_end");
    rd_reg(4'h4, 32'h00FF_00FC);
    `CHK("irq", 1'b1, irq_o)
    `CHK("chan_on", 1'b0, channel_on_o)
    wr_reg(4'h4, 32'h00FF_00FF);
    rd_reg(4'h4, 32'h00FF_0000);
    `CHK("irq_clr", 1'b0, irq_o)
    stall <= 1'b1;
    wr_reg(4'h8, 32'h0000_0090);
    wr_reg(4'h0, 32'h0021_1220);
    far.fire(8'h12);
    settle(1'b0, "busy_sirq_off");
    wr_reg(4'h0, 32'h0021_12A0);
    wait_out(2, "force_busy");
    rd_reg(4'h0, 32'h0021_1220);
    far.fire(8'h21);
    settle(1'b1, "busy_airq_off");
    wr_reg(4'h0, 32'h0021_1228);
    far.fire(8'h21);
    wait_out(1, "abort_irq");
    `CHK("busy_abort", 1'b0, busy_o)
    rd_reg(4'h4, 32'h00FF_0002);
    `CHK("irq_abort", 1'b1, irq_o)
    wr_reg(4'h4, 32'h00FF_00FF);
    stall <= 1'b0;
    wr_reg(4'h0, 32'h0021_12A8);
    wait_out(0, "force_start");
    wait_out(3, "auto_end");
    `CHK("chan_auto", 1'b1, channel_on_o)
    wr_reg(4'h4, 32'h00FF_00FF);
    stall <= 1'b1;
    wr_reg(4'h0, 32'h0021_12A8);
    wait_out(2, "busy_sw");
    wr_reg(4'h0, 32'h0021_1268);
    wait_out(1, "sw_abort");
    rd_reg(4'h0, 32'h0021_1228);
    rd_reg(4'h4, 32'h00FF_0000);
    wr_reg(4'h0, 32'h0021_12A8);
    wait_out(2, "busy_pat");
    far.pulse(1'b1);
    wait_out(1, "pat_abort");
    `CHK("chan_pat", 1'b0, channel_on_o)
    rd_reg(4'h4, 32'h00FF_0008);
    far.pulse(1'b0);
    rd_reg(4'h4, 32'h00FF_0009);
    wr_reg(4'h4, 32'h0000_0000);
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK("irq_mask", 1'b0, irq_o)
    wr_reg(4'h4, 32'h0001_0000);
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK("irq_one", 1'b1, irq_o)
    wr_reg(4'h8, 32'h0000_0040);
    wr_reg(4'h0, 32'h0021_1238);
    far.fire(8'h12);
    settle(1'b0, "busy_allow_off");
    wr_reg(4'h8, 32'h0000_00C0);
    wait_out(2, "allow_start");
    rd_reg(4'h8, 32'h0000_80C0);
    finish_test;
  end
endmodule
